// >>> rtl/irq_pkg.sv
/*
 * Shared constants and types of the RF frontend interrupt unit:
 * register indices, flag positions, reset values and the event carrier.
 * Assumes nothing of its surroundings; imported by no one, used by name.
 */
package irq_pkg;

   localparam int NUM_FLAGS = 20;
   localparam int NUM_MASKED = 17;
   localparam int SEL_W = 6;
   localparam int SEL_LSB = 4;
   localparam int IDX_W = 4;

   // Register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_ENABLE = 4'h1;
   localparam logic [IDX_W-1:0] IDX_STATUS = 4'h2;
   localparam logic [IDX_W-1:0] IDX_CLEAR = 4'h3;
   localparam logic [IDX_W-1:0] IDX_XCV_CTRL = 4'h4;

   // Flag positions, shared by status, enable and clear registers
   localparam int BIT_RX_END = 0;
   localparam int BIT_TX_END = 1;
   localparam int BIT_IDLE = 2;
   localparam int BIT_EXT_MOD = 3;
   localparam int BIT_CARD_ACT = 4;
   localparam int BIT_STATE_CHG = 5;
   localparam int BIT_EXT_OFF = 6;
   localparam int BIT_EXT_ON = 7;
   localparam int BIT_OWN_OFF = 8;
   localparam int BIT_OWN_ON = 9;
   localparam int BIT_FLD_ERR = 10;
   localparam int BIT_TMR_A = 11;
   localparam int BIT_TMR_B = 12;
   localparam int BIT_TMR_C = 13;
   localparam int BIT_SOF = 14;
   localparam int BIT_SUBC = 15;
   localparam int BIT_OVERTEMP = 16;
   localparam int BIT_GEN_ERR = 17;
   localparam int BIT_NVM_FAIL = 18;
   localparam int BIT_LP_DET = 19;

   localparam logic [NUM_FLAGS-1:0] STATUS_RST = 20'h00000;
   localparam logic [NUM_MASKED-1:0] ENABLE_RST = 17'h00000;
   localparam logic [SEL_W-1:0] SEL_RST = 6'h00;

   localparam logic [2:0] HSIZE_WORD = 3'h2;

   // One-cycle event pulses from the sources; state change is made by state_entry_detect
   typedef struct packed {
      logic lowpower_detect;
      logic nvm_program_fail;
      logic general_error;
      logic overtemp;
      logic subcarrier_seen;
      logic frame_start_seen;
      logic tmr_c;
      logic tmr_b;
      logic tmr_a;
      logic field_active_error;
      logic own_field_on;
      logic own_field_off;
      logic ext_field_on;
      logic ext_field_off;
      logic card_activated;
      logic ext_modulation;
      logic idle_entered;
      logic tx_end;
      logic rx_end;
   } src_events_t;

endpackage

// >>> rtl/sticky_flag_bank.sv
/*
 * Bank of sticky event flags with per-bit set and clear.
 * Assumes set pulses and clear strobes synchronous to the one clock.
 */
`timescale 1ns/1ns
module sticky_flag_bank #(
   parameter int WIDTH = irq_pkg::NUM_FLAGS
) (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic [WIDTH-1:0] set_i,
   input wire logic [WIDTH-1:0] clr_i,
   output logic [WIDTH-1:0] flags_o
);

   typedef struct packed {
      logic [WIDTH-1:0] flags;
   } bank_state_t;

   bank_state_t state_q;
   bank_state_t state_d;

   always_comb begin
      state_d = state_q;
      for (int i = 0; i < WIDTH; i++) begin
         // Set wins over a clear in the same cycle
         state_d.flags[i] = set_i[i] | (state_q.flags[i] & ~clr_i[i]);
      end
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign flags_o = state_q.flags;

endmodule

// >>> rtl/state_entry_detect.sv
/*
 * Pulses when the transceive state machine enters a selected state.
 * Assumes a one-hot state code from the transceive logic.
 */
`timescale 1ns/1ns
module state_entry_detect #(
   parameter int SEL_W = irq_pkg::SEL_W
) (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic [SEL_W-1:0] state_i,
   input wire logic [SEL_W-1:0] select_i,
   output logic entered_o
);

   typedef struct packed {
      logic [SEL_W-1:0] prev;
   } det_state_t;

   det_state_t state_q;
   det_state_t state_d;

   always_comb begin
      state_d.prev = state_i;
   end

   // All-zero select never fires
   assign entered_o = (state_i != state_q.prev) &&
                      ((state_i & select_i) != '0);

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

endmodule

// >>> rtl/rf_frontend_irq_unit.sv
/*
 * Interrupt aggregation of the RF frontend: sticky status flags, enable
 * mask, write-one clear register, state-trigger select, AHB-Lite slave
 * and one level interrupt output.
 * Assumes event pulses synchronous to ref_clk_i, a single AHB master and
 * a one-hot transceive state code.
 */
// Our own choice: register access over AHB-Lite.
// Overview of operation
// - A flag reaches the interrupt pin only when its enable bit is set.
// - Bit 0 marks reception end, bit 1 marks transmission end.
// - Bit 2 marks idle entry, bit 3 external modulation detected.
// - Bit 4 marks card activation, bit 5 transceive state change.
// - Bit 6 external field off, bit 7 external field on.
// - Bit 8 own field off, bit 9 own field on, reader role.
// - Bit 10 field active error, gated by enable bit 10.
// - Bits 11 to 13 are timer expiries, each with own enable.
// - Bit 14 frame start seen, bit 15 subcarrier seen.
// - Bit 16 overtemperature with enable 16; enable bits 31:17 read zero.
// - Bits 17-19 general error, program fail, low-power detect; no enable.
// - Status is read-only, bits 31:20 reserved; writes to it never change flags.
// - Writing one to a clear register bit resets that status flag.
// - State-change flag only for states picked in the six-bit select field.
`timescale 1ns/1ns
module rf_frontend_irq_unit #(
   parameter int NUM_FLAGS = irq_pkg::NUM_FLAGS,
   parameter int NUM_MASKED = irq_pkg::NUM_MASKED,
   parameter int SEL_W = irq_pkg::SEL_W
) (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   input wire irq_pkg::src_events_t events_i,
   input wire logic [SEL_W-1:0] trans_state_i,
   output logic irq_o
);

   typedef struct packed {
      logic [NUM_MASKED-1:0] mask;
      logic [SEL_W-1:0] select;
      logic wr_pend;
      logic [irq_pkg::IDX_W-1:0] wr_idx;
      logic [31:0] rdata;
      logic irq;
      logic ready;
      logic resp;
   } unit_state_t;

   unit_state_t state_q;
   unit_state_t state_d;

   logic [NUM_FLAGS-1:0] flags;
   logic [NUM_FLAGS-1:0] set_vec;
   logic [NUM_FLAGS-1:0] clr_vec;
   logic state_chg;
   logic addr_ok;
   logic [irq_pkg::IDX_W-1:0] addr_idx;

   // Index of a word address, or out of range if above the map
   function automatic logic [irq_pkg::IDX_W:0] word_index(
      input logic [31:0] addr);
      logic [irq_pkg::IDX_W:0] idx;
      idx = '1;
      if (addr[31:irq_pkg::IDX_W+2] == '0) begin
         idx = {1'b0, addr[irq_pkg::IDX_W+1:2]};
      end
      return idx;
   endfunction

   function automatic logic hit(input logic [irq_pkg::IDX_W:0] idx,
                                input logic [irq_pkg::IDX_W-1:0] reg_idx);
      return idx == {1'b0, reg_idx};
   endfunction

   logic [irq_pkg::IDX_W:0] cur_idx;
   logic addr_phase;

   assign cur_idx = word_index(haddr_i);
   assign addr_idx = cur_idx[irq_pkg::IDX_W-1:0];
   assign addr_ok = ~cur_idx[irq_pkg::IDX_W];
   assign addr_phase = hsel_i & htrans_i[1] & hready_i;

   state_entry_detect #(
      .SEL_W(SEL_W)
   ) u_state_entry (
      .ref_clk_i(ref_clk_i),
      .resetn_i(resetn_i),
      .state_i(trans_state_i),
      .select_i(state_q.select),
      .entered_o(state_chg)
   );

   always_comb begin
      set_vec = '0;
      set_vec[irq_pkg::BIT_RX_END] = events_i.rx_end;
      set_vec[irq_pkg::BIT_TX_END] = events_i.tx_end;
      set_vec[irq_pkg::BIT_IDLE] = events_i.idle_entered;
      set_vec[irq_pkg::BIT_EXT_MOD] = events_i.ext_modulation;
      set_vec[irq_pkg::BIT_CARD_ACT] = events_i.card_activated;
      set_vec[irq_pkg::BIT_STATE_CHG] = state_chg;
      set_vec[irq_pkg::BIT_EXT_OFF] = events_i.ext_field_off;
      set_vec[irq_pkg::BIT_EXT_ON] = events_i.ext_field_on;
      set_vec[irq_pkg::BIT_OWN_OFF] = events_i.own_field_off;
      set_vec[irq_pkg::BIT_OWN_ON] = events_i.own_field_on;
      set_vec[irq_pkg::BIT_FLD_ERR] = events_i.field_active_error;
      set_vec[irq_pkg::BIT_TMR_A] = events_i.tmr_a;
      set_vec[irq_pkg::BIT_TMR_B] = events_i.tmr_b;
      set_vec[irq_pkg::BIT_TMR_C] = events_i.tmr_c;
      set_vec[irq_pkg::BIT_SOF] = events_i.frame_start_seen;
      set_vec[irq_pkg::BIT_SUBC] = events_i.subcarrier_seen;
      set_vec[irq_pkg::BIT_OVERTEMP] = events_i.overtemp;
      set_vec[irq_pkg::BIT_GEN_ERR] = events_i.general_error;
      set_vec[irq_pkg::BIT_NVM_FAIL] = events_i.nvm_program_fail;
      set_vec[irq_pkg::BIT_LP_DET] = events_i.lowpower_detect;
   end

   always_comb begin
      clr_vec = '0;
      // Write-one clear, applied in the data phase
      if (state_q.wr_pend && state_q.wr_idx == irq_pkg::IDX_CLEAR) begin
         clr_vec = hwdata_i[NUM_FLAGS-1:0];
      end
      // Read of status clears exactly what the read returned
      if (addr_phase && !hwrite_i && addr_ok &&
          hit(cur_idx, irq_pkg::IDX_STATUS)) begin
         clr_vec = clr_vec | flags;
      end
   end

   sticky_flag_bank #(
      .WIDTH(NUM_FLAGS)
   ) u_flags (
      .ref_clk_i(ref_clk_i),
      .resetn_i(resetn_i),
      .set_i(set_vec),
      .clr_i(clr_vec),
      .flags_o(flags)
   );

   always_comb begin
      state_d = state_q;
      state_d.wr_pend = 1'b0;
      // Zero-wait slave, always OKAY
      state_d.ready = 1'b1;
      state_d.resp = 1'b0;
      // Data phase of a write: the status index has no write path
      if (state_q.wr_pend) begin
         unique case (state_q.wr_idx)
            irq_pkg::IDX_ENABLE: begin
               state_d.mask = hwdata_i[NUM_MASKED-1:0];
            end
            irq_pkg::IDX_XCV_CTRL: begin
               state_d.select = hwdata_i[irq_pkg::SEL_LSB +: SEL_W];
            end
            default: begin
               state_d.mask = state_q.mask;
            end
         endcase
      end
      if (addr_phase) begin
         state_d.rdata = '0;
         if (hwrite_i) begin
            // Only whole-word writes to mapped words take effect
            state_d.wr_pend = addr_ok && (hsize_i == irq_pkg::HSIZE_WORD);
            state_d.wr_idx = addr_idx;
         end else if (addr_ok) begin
            if (hit(cur_idx, irq_pkg::IDX_ENABLE)) begin
               state_d.rdata[NUM_MASKED-1:0] = state_q.mask;
            end else if (hit(cur_idx, irq_pkg::IDX_STATUS)) begin
               state_d.rdata[NUM_FLAGS-1:0] = flags;
            end else if (hit(cur_idx, irq_pkg::IDX_XCV_CTRL)) begin
               state_d.rdata[irq_pkg::SEL_LSB +: SEL_W] = state_q.select;
            end
         end
      end
      // Unmasked top flags have no enable and never reach the pin
      state_d.irq = |(flags[NUM_MASKED-1:0] & state_q.mask);
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_q.mask <= irq_pkg::ENABLE_RST;
         state_q.select <= irq_pkg::SEL_RST;
         state_q.wr_pend <= 1'b0;
         state_q.wr_idx <= '0;
         state_q.rdata <= 32'h00000000;
         state_q.irq <= 1'b0;
         state_q.ready <= 1'b1;
         state_q.resp <= 1'b0;
      end else begin
         state_q <= state_d;
      end
   end

   assign hrdata_o = state_q.rdata;
   assign hreadyout_o = state_q.ready;
   assign hresp_o = state_q.resp;
   assign irq_o = state_q.irq;

endmodule

// >>> tb/irq_monitor.sv
/* Port checker for the interrupt unit.
   Assumes the bind below and hready fed back from hreadyout. */
`timescale 1ns/1ns
module irq_monitor #(
   parameter int SEL_W = irq_pkg::SEL_W
) (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic hready_i,
   input wire logic [31:0] hrdata_o,
   input wire irq_pkg::src_events_t events_i,
   input wire logic [SEL_W-1:0] trans_state_i,
   input wire logic irq_o
);
   logic acc;
   logic cause;
   assign acc = hsel_i && htrans_i[1] && hready_i;
   // Only maskable sources or a bus write can start the pin
   assign cause = (|events_i[15:0]) || (acc && hwrite_i);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);
   AST_RST_IDLE: assert property ($rose(resetn_i) |-> !irq_o
      && hrdata_o == 32'h0) else $error("irq or data set after reset");
   AST_IRQ_CAUSE: assert property ($rose(irq_o) |-> $past(cause, 2)
      || $past(cause, 3) || $past(trans_state_i, 2) != $past(trans_state_i, 3))
      else $error("irq rose without cause");
   AST_IRQ_FALL: assert property ($fell(irq_o) |-> $past(acc, 2)
      || $past(acc, 3)) else $error("irq fell without bus access");
   AST_IRQ_HOLD: assert property ((irq_o && !acc)[*3] |=> irq_o)
      else $error("irq dropped on its own");
   AST_STATUS_RSVD: assert property (acc && !hwrite_i
      && haddr_i == 32'h8 |=> hrdata_o[31:20] == 12'h0)
      else $error("status reserved bits set");
   AST_ENABLE_RSVD: assert property (acc && !hwrite_i
      && haddr_i == 32'h4 |=> hrdata_o[31:17] == 15'h0)
      else $error("enable reserved bits set");
   AST_CLEAR_ZERO: assert property (acc && !hwrite_i
      && haddr_i == 32'hc |=> hrdata_o == 32'h0)
      else $error("clear register read nonzero");
   AST_UNMAPPED_ZERO: assert property (acc && !hwrite_i
      && haddr_i == 32'h0 |=> hrdata_o == 32'h0)
      else $error("unmapped read nonzero");
   cover property ($rose(irq_o));
   cover property ($fell(irq_o));
   cover property (acc && haddr_i == 32'h8);
endmodule
bind rf_frontend_irq_unit irq_monitor #(.SEL_W(SEL_W)) u_mon (.*);

// >>> tb/irq_host_model.sv
/* Host side of the interrupt pin: counts requests.
   Assumes a level pin synchronous to the one clock. */
`timescale 1ns/1ns
module irq_host_model (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic irq_i,
   output int irq_count_o
);
   logic irq_q;
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         irq_q <= 1'b0;
         irq_count_o <= 0;
      end else begin
         irq_q <= irq_i;
         if (irq_i && !irq_q) begin
            irq_count_o <= irq_count_o + 1;
         end
      end
   end
endmodule

// >>> tb/test_rf_frontend_irq_unit.sv
/* Self-checking bench of the interrupt unit.
   Assumes a single AHB slave answering with hreadyout. */
`timescale 1ns/1ns
module test_rf_frontend_irq_unit;
   logic ref_clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic hsel_i = 1'b0;
   logic [31:0] haddr_i = 32'h0;
   logic [1:0] htrans_i = 2'h0;
   logic hwrite_i = 1'b0;
   logic [2:0] hsize_i = 3'h2;
   logic [2:0] bus_size = irq_pkg::HSIZE_WORD;
   logic [31:0] hwdata_i = 32'h0;
   irq_pkg::src_events_t events_i = '0;
   logic [5:0] trans_state_i = 6'h00;
   logic [31:0] hrdata_o;
   logic hreadyout_o;
   logic hresp_o;
   logic irq_o;
   int irq_count;
   int errors = 0;
   int checks = 0;
   rf_frontend_irq_unit dut (.ref_clk_i, .resetn_i, .hsel_i, .haddr_i,
      .htrans_i, .hwrite_i, .hsize_i, .hwdata_i, .hready_i(hreadyout_o),
      .hrdata_o, .hreadyout_o, .hresp_o, .events_i, .trans_state_i, .irq_o);
   irq_host_model host (.ref_clk_i, .resetn_i, .irq_i(irq_o),
      .irq_count_o(irq_count));
   initial begin
      forever #20 ref_clk_i = ~ref_clk_i;
   end
   task automatic check(string what, logic [31:0] exp, logic [31:0] got);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic bus(logic is_wr, logic [31:0] a, logic [31:0] wd,
                      output logic [31:0] rdata);
      hsel_i <= 1'b1;
      htrans_i <= 2'h2;
      hwrite_i <= is_wr;
      haddr_i <= a;
      hsize_i <= bus_size;
      @(posedge ref_clk_i);
      while (hreadyout_o !== 1'b1) @(posedge ref_clk_i);
      hsel_i <= 1'b0;
      htrans_i <= 2'h0;
      hwdata_i <= wd;
      @(posedge ref_clk_i);
      while (hreadyout_o !== 1'b1) @(posedge ref_clk_i);
      rdata = hrdata_o;
   endtask
   task automatic wr(logic [31:0] a, logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask
   task automatic rd(logic [31:0] a, logic [31:0] exp, string what);
      logic [31:0] x;
      bus(1'b0, a, 32'h0, x);
      check(what, exp, x);
   endtask
   // Event struct skips flag 5, which the state detector makes
   task automatic pulse(int k);
      events_i <= irq_pkg::src_events_t'(19'h1 << k);
      @(posedge ref_clk_i);
      events_i <= '0;
      @(posedge ref_clk_i);
   endtask
   // Reads right after an edge see the settled pre-edge values
   task automatic settle;
      repeat (2) @(posedge ref_clk_i);
   endtask
   task automatic t_reset;
      check("irq", 32'h0, {31'h0, irq_o});
      rd(32'h4, 32'h0, "enable");
      rd(32'h8, 32'h0, "status");
      rd(32'h0, 32'h0, "unmapped");
   endtask
   task automatic t_flags;
      for (int k = 0; k < 19; k++) begin
         pulse(k);
         settle();
         check("irq", 32'h0, {31'h0, irq_o});
         rd(32'h8, 32'h1 << (k < 5 ? k : k + 1), "status");
      end
   endtask
   task automatic t_mask;
      wr(32'h4, 32'hffffffff);
      rd(32'h4, 32'h0001ffff, "enable");
      pulse(10);
      settle();
      check("irq", 32'h1, {31'h0, irq_o});
      wr(32'hc, 32'h800);
      settle();
      check("irq", 32'h0, {31'h0, irq_o});
      pulse(16);
      settle();
      check("irq", 32'h0, {31'h0, irq_o});
      rd(32'h8, 32'h20000, "status");
      pulse(11);
      settle();
      wr(32'h4, 32'h0);
      settle();
      check("irq", 32'h0, {31'h0, irq_o});
      rd(32'h8, 32'h1000, "status");
      check("irq count", 32'h2, 32'(irq_count));
   endtask
   task automatic t_ro;
      wr(32'h8, 32'hfffff);
      check("hresp", 32'h0, {31'h0, hresp_o});
      check("hready", 32'h1, {31'h0, hreadyout_o});
      rd(32'h8, 32'h0, "status");
      rd(32'hc, 32'h0, "clear");
      // Narrow writes are dropped, so the mask must stay clear
      bus_size = 3'h0;
      wr(32'h4, 32'h1);
      bus_size = irq_pkg::HSIZE_WORD;
      rd(32'h4, 32'h0, "enable");
   endtask
   task automatic t_state;
      wr(32'h10, 32'h20);
      trans_state_i <= 6'h01;
      settle();
      rd(32'h8, 32'h0, "status");
      trans_state_i <= 6'h02;
      settle();
      rd(32'h8, 32'h20, "status");
      wr(32'h10, 32'h0);
      trans_state_i <= 6'h04;
      settle();
      rd(32'h8, 32'h0, "status");
   endtask
   task automatic print_verdict;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge ref_clk_i);
      errors++;
      print_verdict();
   end
   initial begin
      repeat (12) @(posedge ref_clk_i);
      resetn_i <= 1'b1;
      @(posedge ref_clk_i);
      t_reset();
      t_flags();
      t_mask();
      t_ro();
      t_state();
      print_verdict();
   end
endmodule
